// ### core/bml_pkg.sv
package bml_pkg;

	// Clock rate and serial clock ratio.
	localparam int unsigned CLK_MHZ         = 200;
	localparam int unsigned SCLK_DIVIDE     = 256;
	localparam int unsigned SCLK_HALF       = SCLK_DIVIDE / 2;
	localparam int unsigned DIV_W           = $clog2(SCLK_DIVIDE);
	localparam logic [7:0]  DIV_RISE        = 8'h00;

	// Stream length and counter width.
	localparam int unsigned STREAM_BITS     = 256;
	localparam int unsigned CNT_W           = 9;
	localparam logic [8:0]  CNT_LAST        = 9'h0ff;
	localparam int unsigned STREAM_WORDS    = STREAM_BITS / 32;

	// Field positions in the stream.
	localparam int unsigned POS_ORDER       = 0;
	localparam int unsigned POS_CHECK       = 1;
	localparam int unsigned POS_ENDIAN      = 2;
	localparam int unsigned POS_DSH         = 3;
	localparam int unsigned POS_NO_L2       = 4;
	localparam int unsigned POS_SYSTEM_PORT_WIDTH_LO  = 5;
	localparam int unsigned POS_L2PORT      = 7;
	localparam int unsigned POS_SPLIT       = 8;
	localparam int unsigned POS_LINE_LO     = 9;
	localparam int unsigned POS_PAT_LO      = 11;
	localparam int unsigned POS_DIV_LO      = 15;
	localparam int unsigned POS_RSVD18      = 18;

	// Highest legal field encodings.
	localparam logic [3:0]  PAT_MAX         = 4'h8;
	localparam logic [2:0]  DIV_MAX         = 3'h4;

	// Register byte offsets.
	localparam logic [5:0]  OFS_CTRL        = 6'h00;
	localparam logic [5:0]  OFS_STATUS      = 6'h04;
	localparam logic [5:0]  OFS_MODES       = 6'h08;
	localparam logic [5:0]  OFS_STREAM      = 6'h20;

	// Control and status bit positions.
	localparam int unsigned CTRL_RELOAD     = 0;
	localparam int unsigned ST_DONE         = 0;
	localparam int unsigned ST_BUSY         = 1;
	localparam int unsigned ST_RSVD_ERR     = 2;
	localparam int unsigned ST_CNT_LO       = 8;

	// AXI responses.
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_DECERR     = 2'h3;

	// Loader states, Gray coded along idle, load, done.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOAD = 2'h1,
		ST_FULL = 2'h3
	} bml_state_t;

endpackage : bml_pkg

// ### core/bml_boot_loader.sv
`timescale 1ns/1ps
`default_nettype none

module bml_boot_loader (
	input  wire logic        aclk,                  // System clock, 200 MHz.
	input  wire logic        aresetn,               // Synchronous reset, active low.
	// AXI4-Lite slave.
	input  wire logic [5:0]  s_axi_awaddr,          // Write address.
	input  wire logic        s_axi_awvalid,         // Write address valid.
	output logic             s_axi_awready,         // Write address ready.
	input  wire logic [31:0] s_axi_wdata,           // Write data.
	input  wire logic [3:0]  s_axi_wstrb,           // Write byte strobes.
	input  wire logic        s_axi_wvalid,          // Write data valid.
	output logic             s_axi_wready,          // Write data ready.
	output logic [1:0]       s_axi_bresp,           // Write response.
	output logic             s_axi_bvalid,          // Write response valid.
	input  wire logic        s_axi_bready,          // Write response ready.
	input  wire logic [5:0]  s_axi_araddr,          // Read address.
	input  wire logic        s_axi_arvalid,         // Read address valid.
	output logic             s_axi_arready,         // Read address ready.
	output logic [31:0]      s_axi_rdata,           // Read data.
	output logic [1:0]       s_axi_rresp,           // Read response.
	output logic             s_axi_rvalid,          // Read data valid.
	input  wire logic        s_axi_rready,          // Read data ready.
	// Serial configuration link.
	input  wire logic        supply_good_in,        // Supply good, active high.
	output logic             serial_clk_out,        // Serial clock to the EPROM.
	input  wire logic        serial_data_in,        // Serial stream bit.
	// Decoded modes.
	output logic             load_done,             // Modes valid and held.
	output logic             block_response_order,  // 0 sequential, 1 sub-block.
	output logic             check_bus_mode,        // 0 SECDED, 1 byte parity.
	output logic             byte_order_select,     // 0 little, 1 big endian.
	output logic             dirty_shared_disable,  // 1 blocks dirty-shared moves.
	output logic             no_second_level_cache, // 1 when no L2 cache.
	output logic [1:0]       system_port_width,     // 0 is 64 bits.
	output logic             l2_port_width,         // 0 is 128 bits.
	output logic             l2_split_organization, // 1 split I and D.
	output logic [1:0]       l2_line_size,          // Line size code.
	output logic [5:0]       l2_line_words,         // Line size in words.
	output logic [3:0]       transmit_data_pattern, // Data pattern code.
	output logic [2:0]       system_clock_divisor,  // Divisor code.
	output logic [3:0]       system_clock_ratio,    // Divisor as a number.
	output logic             mode_reserved_error    // A reserved code was loaded.
);

	////////////////////////////////////////////////////////////////////////////////
	// Serial clock divider.

	logic [7:0]              div_q;
	logic                    sclk_q;
	logic                    sample_en;

	// Free-running divider; it never stops, even after loading.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// Serial clock is high for the first half of each 256-cycle period.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= (div_q + 8'h01) < 8'(bml_pkg::SCLK_HALF);
		end
	end

	// One-cycle pulse on the edge where the serial clock rises.
	assign sample_en      = (div_q == bml_pkg::DIV_RISE) && aresetn;
	assign serial_clk_out = sclk_q;

	////////////////////////////////////////////////////////////////////////////////
	// Load sequencer.

	bml_pkg::bml_state_t     state_q;
	logic                    good_q;
	logic                    start;
	logic                    reload_req;
	logic [8:0]              cnt_q;
	logic [255:0]            cap_q;

	// Supply-good edge history.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			good_q <= 1'b0;
		end else begin
			good_q <= supply_good_in;
		end
	end

	// A new load starts on supply-good rising or on a software reload.
	assign start = (supply_good_in && !good_q) || (reload_req && supply_good_in);

	// Idle until supply is good, load 256 bits, then stay full.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= bml_pkg::ST_IDLE;
		end else if (!supply_good_in) begin
			state_q <= bml_pkg::ST_IDLE;
		end else if (start) begin
			state_q <= bml_pkg::ST_LOAD;
		end else begin
			case (state_q)
				bml_pkg::ST_LOAD: begin
					if (sample_en && cnt_q == bml_pkg::CNT_LAST) begin
						state_q <= bml_pkg::ST_FULL;
					end
				end
				default: begin
					state_q <= state_q;
				end
			endcase
		end
	end

	// Count of bits taken in the current load.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 9'h000;
		end else if (start) begin
			cnt_q <= 9'h000;
		end else if (state_q == bml_pkg::ST_LOAD && sample_en) begin
			cnt_q <= cnt_q + 9'h001;
		end
	end

	// Shift right, newest bit at the top; bit 0 lands in position 0 at the end.
	// Outside a load the data input is not looked at.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_q <= '0;
		end else if (state_q == bml_pkg::ST_LOAD && !start && sample_en) begin
			cap_q <= {serial_data_in, cap_q[255:1]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode and hold.

	logic                    fin;
	logic                    rsvd_d;
	logic [3:0]              ratio_d;

	// Last bit of the stream is being taken this cycle.
	assign fin = state_q == bml_pkg::ST_LOAD && !start && sample_en
		&& cnt_q == bml_pkg::CNT_LAST;

	// Reserved encodings, checked on the full stream including the last bit.
	always_comb begin
		logic [255:0] s;
		s      = {serial_data_in, cap_q[255:1]};
		rsvd_d = (s[bml_pkg::POS_SYSTEM_PORT_WIDTH_LO +: 2] != 2'h0)
			|| s[bml_pkg::POS_L2PORT]
			|| (s[bml_pkg::POS_PAT_LO +: 4] > bml_pkg::PAT_MAX)
			|| (s[bml_pkg::POS_DIV_LO +: 3] > bml_pkg::DIV_MAX)
			|| s[bml_pkg::POS_RSVD18];
	end

	// Divisor code to ratio; reserved codes give zero.
	always_comb begin
		case (cap_q[bml_pkg::POS_DIV_LO +: 3])
			3'h0:    ratio_d = 4'h2;
			3'h1:    ratio_d = 4'h3;
			3'h2:    ratio_d = 4'h4;
			3'h3:    ratio_d = 4'h6;
			3'h4:    ratio_d = 4'h8;
			default: ratio_d = 4'h0;
		endcase
	end

	// Done flag and reserved flag follow the end of each load.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_done           <= 1'b0;
			mode_reserved_error <= 1'b0;
		end else if (fin) begin
			load_done           <= 1'b1;
			mode_reserved_error <= rsvd_d;
		end else if (start || !supply_good_in) begin
			load_done           <= 1'b0;
		end
	end

	// Mode outputs load on the same edge that takes the last bit and then hold.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			block_response_order  <= 1'b0;
			check_bus_mode        <= 1'b0;
			byte_order_select     <= 1'b0;
			dirty_shared_disable  <= 1'b0;
			no_second_level_cache <= 1'b0;
			system_port_width     <= 2'h0;
			l2_port_width         <= 1'b0;
			l2_split_organization <= 1'b0;
			l2_line_size          <= 2'h0;
			transmit_data_pattern <= 4'h0;
			system_clock_divisor  <= 3'h0;
		end else if (fin) begin
			block_response_order  <= cap_q[bml_pkg::POS_ORDER + 1];
			check_bus_mode        <= cap_q[bml_pkg::POS_CHECK + 1];
			byte_order_select     <= cap_q[bml_pkg::POS_ENDIAN + 1];
			dirty_shared_disable  <= cap_q[bml_pkg::POS_DSH + 1];
			no_second_level_cache <= cap_q[bml_pkg::POS_NO_L2 + 1];
			system_port_width     <= cap_q[bml_pkg::POS_SYSTEM_PORT_WIDTH_LO + 1 +: 2];
			l2_port_width         <= cap_q[bml_pkg::POS_L2PORT + 1];
			l2_split_organization <= cap_q[bml_pkg::POS_SPLIT + 1];
			l2_line_size          <= cap_q[bml_pkg::POS_LINE_LO + 1 +: 2];
			transmit_data_pattern <= cap_q[bml_pkg::POS_PAT_LO + 1 +: 4];
			system_clock_divisor  <= cap_q[bml_pkg::POS_DIV_LO + 1 +: 3];
		end
	end

	// Derived numbers from the held codes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			l2_line_words      <= 6'h00;
			system_clock_ratio <= 4'h0;
		end else if (load_done) begin
			l2_line_words      <= 6'h04 << l2_line_size;
			system_clock_ratio <= ratio_d_held(system_clock_divisor);
		end
	end

	// Maps a held divisor code to its ratio.
	function automatic logic [3:0] ratio_d_held(input logic [2:0] c);
		case (c)
			3'h0:    ratio_d_held = 4'h2;
			3'h1:    ratio_d_held = 4'h3;
			3'h2:    ratio_d_held = 4'h4;
			3'h3:    ratio_d_held = 4'h6;
			3'h4:    ratio_d_held = 4'h8;
			default: ratio_d_held = 4'h0;
		endcase
	endfunction : ratio_d_held

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write side.

	logic                    aw_have_q;
	logic                    w_have_q;
	logic [5:0]              aw_addr_q;
	logic [31:0]             w_data_q;
	logic [3:0]              w_strb_q;
	logic                    wr_go;

	// Address and data are taken independently, one write at a time.
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign wr_go         = aw_have_q && w_have_q;

	// Hold the write address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 6'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
		end
	end

	// Hold the write data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_go) begin
			w_have_q <= 1'b0;
		end
	end

	// Reload pulse from the control register; needs supply good to act.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reload_req <= 1'b0;
		end else begin
			reload_req <= wr_go && aw_addr_q == bml_pkg::OFS_CTRL && w_strb_q[0]
				&& w_data_q[bml_pkg::CTRL_RELOAD];
		end
	end

	// Write response one cycle after both halves are held.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= bml_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr_q[5:2] == 4'h0 || aw_addr_q[5:2] == 4'h1
				|| aw_addr_q[5:2] == 4'h2 || aw_addr_q[5] == 1'b1) begin
				s_axi_bresp <= bml_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= bml_pkg::RESP_DECERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read side.

	logic [31:0]             rd_data;
	logic [1:0]              rd_resp;
	logic [18:0]             modes_word;

	// Held mode codes packed as in the stream.
	assign modes_word = {1'b0, system_clock_divisor, transmit_data_pattern,
		l2_line_size, l2_split_organization, l2_port_width, system_port_width,
		no_second_level_cache, dirty_shared_disable, byte_order_select,
		check_bus_mode, block_response_order};

	assign s_axi_arready = !s_axi_rvalid;

	// Read decode.
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_resp = bml_pkg::RESP_OKAY;
		if (s_axi_araddr[5:2] == bml_pkg::OFS_CTRL[5:2]) begin
			rd_data = 32'h0000_0000;
		end else if (s_axi_araddr[5:2] == bml_pkg::OFS_STATUS[5:2]) begin
			rd_data[bml_pkg::ST_DONE]     = load_done;
			rd_data[bml_pkg::ST_BUSY]     = state_q == bml_pkg::ST_LOAD;
			rd_data[bml_pkg::ST_RSVD_ERR] = mode_reserved_error;
			rd_data[bml_pkg::ST_CNT_LO +: 9] = cnt_q;
		end else if (s_axi_araddr[5:2] == bml_pkg::OFS_MODES[5:2]) begin
			rd_data[18:0] = modes_word;
		end else if (s_axi_araddr[5] == bml_pkg::OFS_STREAM[5]) begin
			rd_data = cap_q[{s_axi_araddr[4:2], 5'h00} +: 32];
		end else begin
			rd_resp = bml_pkg::RESP_DECERR;
		end
	end

	// Read answer one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= bml_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_data;
			s_axi_rresp  <= rd_resp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : bml_boot_loader

`default_nettype wire

// ### verification/bml_eprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module bml_eprom_model (
	input  wire logic         serial_clk_out, // Serial clock.
	input  wire logic         supply_good_in, // Supply good.
	input  wire logic [255:0] image,          // Stored stream.
	output logic              serial_data_in  // Stream bit.
);
	int   idx   = 0;
	logic armed = 1'b0;
	// A serial rise seen with supply good arms the stepping, so bit 0 meets the first sample.
	always @(posedge serial_clk_out or negedge supply_good_in) begin
		if (!supply_good_in) begin
			armed <= 1'b0;
		end else begin
			armed <= 1'b1;
		end
	end
	// Bit 0 waits while supply is low; later bits move on the serial fall, clear of the sample.
	always @(negedge serial_clk_out or negedge supply_good_in) begin
		if (!supply_good_in) begin
			idx <= 0;
		end else if (armed) begin
			idx <= idx + 1;
		end
	end
	// Past the stream the line toggles, so a stray late sample shows.
	assign serial_data_in = (idx < 256) ? image[idx[7:0]] : idx[0];
endmodule : bml_eprom_model
`default_nettype wire

// ### verification/bml_boot_loader_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bml_boot_loader_checker (
	input wire logic        aclk,                  // Clock.
	input wire logic        aresetn,               // Reset.
	input wire logic [5:0]  s_axi_araddr,          // Read address.
	input wire logic        s_axi_arvalid,         // Address valid.
	input wire logic        s_axi_arready,         // Address ready.
	input wire logic [31:0] s_axi_rdata,           // Read data.
	input wire logic [1:0]  s_axi_rresp,           // Read response.
	input wire logic        supply_good_in,        // Supply good.
	input wire logic        serial_clk_out,        // Serial clock.
	input wire logic        load_done,             // Modes valid.
	input wire logic        block_response_order,  // Mode.
	input wire logic        check_bus_mode,        // Mode.
	input wire logic        byte_order_select,     // Mode.
	input wire logic        dirty_shared_disable,  // Mode.
	input wire logic        no_second_level_cache, // Mode.
	input wire logic [1:0]  system_port_width,     // Mode.
	input wire logic        l2_port_width,         // Mode.
	input wire logic        l2_split_organization, // Mode.
	input wire logic [1:0]  l2_line_size,          // Mode.
	input wire logic [5:0]  l2_line_words,         // Words.
	input wire logic [3:0]  transmit_data_pattern, // Mode.
	input wire logic [2:0]  system_clock_divisor,  // Mode.
	input wire logic [3:0]  system_clock_ratio     // Ratio.
);
	logic        prev_q;
	logic [1:0]  seen_q;
	logic [7:0]  run_q;
	logic [8:0]  smp_q;
	logic [17:0] modes;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Raw codes in stream order.
	assign modes = {system_clock_divisor, transmit_data_pattern, l2_line_size,
		l2_split_organization, l2_port_width, system_port_width, no_second_level_cache,
		dirty_shared_disable, byte_order_select, check_bus_mode, block_response_order};
	// Length of each serial clock phase; the first two phases after reset are cut short, so skip them.
	always_ff @(posedge aclk) begin
		prev_q <= serial_clk_out;
		if (!aresetn) begin
			seen_q <= 2'h0;
			run_q  <= 8'h00;
		end else if (serial_clk_out != prev_q) begin
			if (seen_q != 2'h2) begin
				seen_q <= seen_q + 2'h1;
			end
			run_q  <= 8'h00;
		end else begin
			run_q <= run_q + 8'h01;
		end
	end
	// Serial samples taken since the supply came good.
	always_ff @(posedge aclk) begin
		if (!aresetn || !supply_good_in)
			smp_q <= 9'h000;
		else if (serial_clk_out && !prev_q && smp_q != 9'h1ff)
			smp_q <= smp_q + 9'h001;
	end
	sclk_period_a: assert property (seen_q == 2'h2 && serial_clk_out != prev_q |-> run_q == 8'h7f)
		else $error("serial clock phase is not 128 cycles");
	load_done_a: assert property (supply_good_in && serial_clk_out && !prev_q && smp_q == 9'h0ff
		|=> load_done) else $error("load not done after 256 samples");
	exact_count_a: assert property ($rose(load_done) |-> smp_q == 9'h100)
		else $error("load done after wrong sample count");
	abort_a: assert property ($fell(supply_good_in) |=> !load_done)
		else $error("done survives supply drop");
	modes_hold_a: assert property (!$rose(load_done) |-> $stable(modes))
		else $error("modes changed outside load end");
	line_words_a: assert property (load_done && $past(load_done)
		|-> l2_line_words == (6'h04 << l2_line_size)) else $error("line words wrong");
	ratio_a: assert property (load_done && $past(load_done) && system_clock_divisor <= 3'h4
		|-> system_clock_ratio == ((system_clock_divisor == 3'h3) ? 4'h6 :
		(system_clock_divisor == 3'h4) ? 4'h8 : 4'h2 + 4'(system_clock_divisor)))
		else $error("clock ratio wrong");
	read_decerr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 6'h0c
		&& s_axi_araddr <= 6'h1f |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	mode_read_a: assert property (s_axi_arvalid && s_axi_arready && load_done &&
		s_axi_araddr == 6'h08 |=> s_axi_rdata[18:0] == {1'h0, modes})
		else $error("mode word differs from ports");
endmodule : bml_boot_loader_checker
bind bml_boot_loader bml_boot_loader_checker i_chk (.*);
`default_nettype wire

// ### verification/bml_boot_loader_test.sv
`timescale 1ns/1ps
`default_nettype none
module bml_boot_loader_test;
	typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] m; logic [1:0] r;} bml_row_t;
	// Legal codes in every field, zero in every reserved place.
	localparam logic [255:0] IMG = {160'h0, 32'h0000_0001, 32'h7344_8086, 32'h9fea_470d};
	logic aclk = 1'h0, aresetn = 1'h0, supply_good_in = 1'h0;
	logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, system_port_width, l2_line_size;
	logic [31:0] s_axi_rdata;
	logic serial_clk_out, serial_data_in, load_done, block_response_order, check_bus_mode;
	logic byte_order_select, dirty_shared_disable, no_second_level_cache, l2_port_width;
	logic l2_split_organization, mode_reserved_error;
	logic [5:0] l2_line_words;
	logic [3:0] transmit_data_pattern, system_clock_ratio;
	logic [2:0] system_clock_divisor;
	int error_cnt = 0, n_checks = 0;
	bml_row_t rows[13];
	bml_boot_loader i_dut (.*);
	bml_eprom_model i_mem (.serial_clk_out(serial_clk_out), .supply_good_in(supply_good_in),
		.image(IMG), .serial_data_in(serial_data_in));
	// Clock of 5 ns.
	initial forever #2.5 aclk = ~aclk;
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_data
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		cmp_data({30'h0, got}, {30'h0, exp});
	endtask : cmp_resp
	task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axi_read
	task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fork
			begin do @(posedge aclk); while (s_axi_awready !== 1'h1); s_axi_awvalid <= 1'h0; end
			begin do @(posedge aclk); while (s_axi_wready !== 1'h1); s_axi_wvalid <= 1'h0; end
		join
		do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axi_write
	task automatic run_rows;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 13; i++) begin
			axi_read(rows[i].a, d, r);
			cmp_data(d & rows[i].m, rows[i].d);
			cmp_resp(r, rows[i].r);
		end
	endtask : run_rows
	task automatic check_modes;
		cmp_data({14'h0, system_clock_divisor, transmit_data_pattern, l2_line_size,
			l2_split_organization, l2_port_width, system_port_width, no_second_level_cache,
			dirty_shared_disable, byte_order_select, check_bus_mode, block_response_order},
			{14'h0, IMG[17:0]});
	endtask : check_modes
	// Supply rises 8 cycles into a low phase so it never meets a sample edge.
	task automatic start_load;
		@(negedge serial_clk_out);
		repeat (8) @(posedge aclk);
		supply_good_in <= 1'h1;
	endtask : start_load
	// Main sequence: row table, then aborted load, full load, writes and late data.
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		for (int k = 0; k < 8; k++)
			rows[k] = '{6'h20 + 6'(4 * k), IMG[32 * k +: 32], 32'hffff_ffff, bml_pkg::RESP_OKAY};
		rows[8] = '{bml_pkg::OFS_MODES, {13'h0, IMG[18:0]}, 32'hffff_ffff, bml_pkg::RESP_OKAY};
		rows[9] = '{bml_pkg::OFS_STATUS, 32'h1, 32'h7, bml_pkg::RESP_OKAY};
		rows[10] = '{bml_pkg::OFS_CTRL, 32'h0, 32'hffff_ffff, bml_pkg::RESP_OKAY};
		rows[11] = '{6'h0c, 32'h0, 32'hffff_ffff, bml_pkg::RESP_DECERR};
		rows[12] = '{6'h1c, 32'h0, 32'hffff_ffff, bml_pkg::RESP_DECERR};
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		start_load();
		repeat (2560) @(posedge aclk);
		axi_read(bml_pkg::OFS_STATUS, d, r);
		cmp_data(d & 32'h3, 32'h2);
		supply_good_in <= 1'h0;
		repeat (4) @(posedge aclk);
		axi_read(bml_pkg::OFS_STATUS, d, r);
		cmp_data(d & 32'h3, 32'h0);
		start_load();
		wait (load_done === 1'h1);
		repeat (3) @(posedge aclk);
		check_modes();
		cmp_data({26'h0, l2_line_words}, 32'h20);
		cmp_data({28'h0, system_clock_ratio}, 32'h8);
		cmp_data({31'h0, mode_reserved_error}, 32'h0);
		run_rows();
		axi_write(bml_pkg::OFS_STATUS, 32'hffff_ffff, r);
		cmp_resp(r, bml_pkg::RESP_OKAY);
		axi_write(6'h10, 32'hffff_ffff, r);
		cmp_resp(r, bml_pkg::RESP_DECERR);
		axi_write(bml_pkg::OFS_CTRL, 32'h0, r);
		cmp_resp(r, bml_pkg::RESP_OKAY);
		repeat (1024) @(posedge aclk);
		check_modes();
		run_rows();
		axi_write(bml_pkg::OFS_CTRL, 32'h1, r);
		cmp_resp(r, bml_pkg::RESP_OKAY);
		axi_read(bml_pkg::OFS_STATUS, d, r);
		cmp_data(d & 32'h3, 32'h2);
		supply_good_in <= 1'h0;
		repeat (2) @(posedge aclk);
		cmp_data({31'h0, load_done}, 32'h0);
		check_modes();
		give_verdict();
	end
	// Watchdog well beyond one full load.
	initial begin
		repeat (90000) @(posedge aclk);
		error_cnt++;
		give_verdict();
	end
endmodule : bml_boot_loader_test
`default_nettype wire
